// [design/dcs_arb.sv]
`timescale 1ns/1ns
`default_nettype none
module dcs_arb (
  input wire logic [3:0] el_in,
  input wire dcs_pkg::dcs_order_t order_in,
  output logic [1:0] win_out,
  output logic any_out
);
  import dcs_pkg::*;
  // slot 0 is the highest rank; scanned last so it overrides
  always_comb begin
    win_out = 2'h0;
    any_out = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      if (el_in[order_in[k*2 +: 2]]) begin
        win_out = order_in[k*2 +: 2];
        any_out = 1'b1;
      end
    end
  end
endmodule : dcs_arb
`default_nettype wire

// [design/dcs_chan.sv]
`timescale 1ns/1ns
`default_nettype none
module dcs_chan (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  dcs_ch_if.chan cif
);
  import dcs_pkg::*;
  dcs_state_e st_r, st_nxt;
  logic fin_r, fin_nxt;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_r <= idle_state; // [RULE7]
      fin_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fin_r <= fin_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    fin_nxt = fin_r;
    case (st_r) // [RULE6]
      idle_state: begin
        if (cif.activate) st_nxt = await_instruction_state; // [RULE8]
      end
      await_instruction_state: begin
        if (cif.err) st_nxt = error_state; // [RULE9]
        else if (cif.fetch_ok && cif.req) st_nxt = await_grant_state; // [RULE10]
      end
      await_grant_state: begin
        if (!cif.link_act) st_nxt = idle_state; // [RULE11]
        else if (cif.win) st_nxt = transfer_state; // [RULE12]
      end
      transfer_state: begin
        if (cif.err) begin
          st_nxt = error_state; // [RULE13] [RULE19]
        end else if (fin_r) begin
          if (!cif.end_flag) begin
            st_nxt = idle_state; // [RULE17]
            fin_nxt = 1'b0;
          end
        end else if (cif.bdone) begin
          if (cif.chained) st_nxt = await_instruction_state; // [RULE17]
          else fin_nxt = 1'b1;
        end else if (cif.udone) begin
          st_nxt = await_grant_state; // [RULE14]
        end else if (cif.glost) begin
          st_nxt = await_regrant_state; // [RULE15]
        end
      end
      await_regrant_state: begin
        if (cif.err) st_nxt = error_state;
        else if (cif.win) st_nxt = transfer_state; // [RULE15]
      end
      error_state: begin
        if (!cif.err) st_nxt = idle_state; // [RULE20]
      end
      default: st_nxt = idle_state;
    endcase
    if (cif.frst) begin
      st_nxt = idle_state; // [RULE7]
      fin_nxt = 1'b0;
    end else if (cif.kill && st_r != idle_state && st_r != error_state) begin
      st_nxt = idle_state; // [RULE18]
      fin_nxt = 1'b0;
    end
  end

  assign cif.st = st_r;
endmodule : dcs_chan
`default_nettype wire

// [design/dcs_top.sv]
// How it works
// RULE1: reset gives disabled, odd parity, all masked, order 0,1,2,3,cascade. Here enable follows the pin and the order holds four channel slots only.
// RULE2: snooped config read at 0x8410 latches the parity select bit.
// RULE3: software may later rewrite parity through the global mode register.
// RULE4: controller runs only while the enable pin is high.
// RULE5: priority order and masks rewritable any time via global register.
// RULE6: each channel owns a six-state machine.
// RULE7: reset or a status flag reset puts a channel in idle.
// RULE8: activating mode write moves idle to await-instruction, no parity check.
// RULE9: fetch eight instruction words; parity error goes to error.
// RULE10: after fetch, hardware request or pending bit moves to await-grant.
// RULE11: mode/link word that deactivates sends channel back to idle.
// RULE12: await-grant holds until the arbiter grants, then transfers.
// RULE13: any transfer error moves the channel straight to error.
// RULE14: single, double, external area modes drop request after each unit.
// RULE15: burst keeps request; lost grant waits in await-regrant.
// RULE16: burst with interval timing counts the interval between transfers.
// RULE17: block end sets end flag and waits, or chains to fetch.
// RULE18: deactivation during transfer abandons it and returns to idle.
// RULE19: parity, protect or address fault during access gives error.
// RULE20: error state raises interrupt; leaves only when error flags clear.
// RULE21: single mode request lasts one bus cycle, dropped within it.
// RULE22: machine cycle is two clocks; peripheral request extends single cycle.
// RULE23: interrupt is one low pulse even for simultaneous errors.
// RULE24: highest ranked waiting channel is served first.
// RULE25: acknowledge of the served channel is low during its transfer.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dcs_cfg.svh"
module dcs_top #(
  parameter int NINS = 8,
  parameter int IWORDS = 8
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`DCS_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic controller_enable_pin_in,
  input wire logic io_cfg_rd_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [15:0] io_data_in,
  input wire logic [3:0] dreq_low_in,
  output logic [3:0] dack_low_out,
  output logic bus_request_low_out,
  input wire logic bus_grant_low_in,
  input wire logic rdy_low_in,
  input wire logic bus_parity_error_in,
  input wire logic memory_protect_fault_in,
  input wire logic external_address_fault_in,
  output logic interrupt_out_low,
  output logic [15:0] bus_addr_out,
  output logic [3:0] ch_state_busy_out,
  input wire dcs_pkg::dcs_order_t fetch_order_in
);
  import dcs_pkg::*;
  localparam int NCH = 4;
  localparam int IW = $clog2(NINS);
  localparam int WW = $clog2(IWORDS);
  localparam int RAW = IW + WW;
  localparam int MCC = `DCS_MC_CLKS;

  // ==========================================================
  // helpers
  function automatic logic par_gen(input logic [15:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : par_gen

  function automatic logic par_ok(input logic [16:0] w, input logic odd);
    return (^w) == odd;
  endfunction : par_ok

  // ==========================================================
  // storage
  logic par_odd_r;
  logic [3:0] mask_r;
  dcs_order_t order_r;
  logic cfg_seen_r;
  logic [16:0] ram [NINS*IWORDS];
  logic [NCH-1:0] act_r, crqp_r, end_of_transfer_flag_r, fetched_r;
  logic [IW-1:0] ins_r [NCH];
  logic [3:0] err_r [NCH];
  logic [15:0] mw_r [NCH];
  logic [15:0] adr_r [NCH];
  logic [15:0] cnt_r [NCH];
  logic [15:0] ivw_r [NCH];
  logic fb_r;
  logic [1:0] fc_r;
  logic [WW-1:0] fw_r;
  logic [1:0] mc_cnt_r;
  logic ov_r;
  logic [1:0] own_r;
  logic [1:0] xph_r;
  logic ucnt_r;
  logic [15:0] ivl_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  logic any_err_d_r;
  logic [15:0] baddr_r;
  dcs_state_e st [NCH];

  // ==========================================================
  // apb decode
  wire en = controller_enable_pin_in; // [RULE4]
  wire setup = psel_in & ~penable_in;
  wire wr = psel_in & penable_in & pwrite_in;
  wire a_g = paddr_in == `DCS_A_GMODE;
  wire a_cm = paddr_in[11:4] == `DCS_PG_CMODE;
  wire a_cs = paddr_in[11:4] == `DCS_PG_CSTAT;
  wire a_ram = paddr_in[11:8] == `DCS_PG_RAM;
  wire [1:0] ach = paddr_in[3:2];
  wire [RAW-1:0] aram = paddr_in[RAW+1:2];
  wire aligned = paddr_in[1:0] == 2'h0;
  wire mapped = aligned & (a_g | a_cm | a_cs | a_ram);
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_g) begin
      rd_mux = {15'h0000, en, order_r, mask_r, 3'h0, par_odd_r};
    end else if (a_cm) begin
      rd_mux = {28'h0000000, 3'(ins_r[ach]), act_r[ach]};
    end else if (a_cs) begin
      rd_mux = {21'h000000, st[ach], 2'h0, err_r[ach],
        end_of_transfer_flag_r[ach], crqp_r[ach]};
    end else if (a_ram) begin
      rd_mux = {15'h0000, ram[aram]};
    end
  end

  // read data is captured at setup so it is stable in the access phase
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= mapped ? rd_mux : 32'h0000_0000;
      pslverr_r <= ~mapped;
    end
  end

  assign prdata_out = prdata_r;
  assign pslverr_out = pslverr_r;
  assign pready_out = 1'b1;

  // ==========================================================
  // global mode and configuration snoop
  wire snoop = io_cfg_rd_in & (io_addr_in == `DCS_CFG_ADDR) & ~cfg_seen_r;
  wire wg = wr & a_g & aligned;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      par_odd_r <= `DCS_RST_PAR; // [RULE1]
      mask_r <= `DCS_RST_MASK;
      order_r <= `DCS_RST_ORD;
      cfg_seen_r <= 1'b0;
    end else begin
      if (snoop) cfg_seen_r <= 1'b1;
      if (wg) begin
        par_odd_r <= pwdata_in[`DCS_G_PAR]; // [RULE3]
        mask_r <= pwdata_in[`DCS_G_MASK_LSB +: 4]; // [RULE5]
        order_r <= pwdata_in[`DCS_G_ORD_LSB +: 8];
      end else if (snoop) begin
        par_odd_r <= io_data_in[`DCS_CFG_PAR_BIT]; // [RULE2]
      end
    end
  end

  // instruction ram carries its parity bit; no reset on purpose
  always_ff @(posedge core_clk_in) begin
    if (wr & a_ram & aligned)
      ram[aram] <= {par_gen(pwdata_in[15:0], par_odd_r), pwdata_in[15:0]};
  end

  // ==========================================================
  // machine cycle divider
  wire mc_tick = mc_cnt_r == 2'(MCC - 1);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) mc_cnt_r <= 2'h0;
    else mc_cnt_r <= mc_tick ? 2'h0 : mc_cnt_r + 2'h1;
  end

  // ==========================================================
  // instruction fetch, one word per machine cycle
  logic [NCH-1:0] fneed;
  logic [1:0] fsel;
  logic fany;
  wire [16:0] fword = ram[{ins_r[fc_r], fw_r}];
  wire fok = par_ok(fword, par_odd_r);
  wire fstep = fb_r & (st[fc_r] == await_instruction_state) & mc_tick;
  wire flast = fw_r == WW'(IWORDS - 1);

  // order taken from the fetch_order_in pins: fetch never touches the bus
  dcs_arb u_farb (
    .el_in(fneed),
    .order_in(fetch_order_in),
    .win_out(fsel),
    .any_out(fany)
  );

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fb_r <= 1'b0;
      fc_r <= 2'h0;
      fw_r <= '0;
    end else if (!fb_r) begin
      if (fany) begin
        fb_r <= 1'b1;
        fc_r <= fsel;
        fw_r <= '0;
      end
    end else if (st[fc_r] != await_instruction_state) begin
      fb_r <= 1'b0;
    end else if (mc_tick) begin
      if (!fok || flast) fb_r <= 1'b0; // [RULE9]
      else fw_r <= WW'(fw_r + 1'b1);
    end
  end

  // ==========================================================
  // bus arbitration and transfer timing
  logic [NCH-1:0] el;
  logic [1:0] win;
  logic wany;
  wire granted = ~bus_grant_low_in;
  wire take = en & granted & ~ov_r & wany;
  dcs_xm_e oxm;
  assign oxm = dcs_xm_e'(mw_r[own_r][`DCS_MW_XM_LSB +: 2]);
  wire ochain = mw_r[own_r][`DCS_MW_CHAIN];
  wire burst = oxm == xm_area_burst;
  wire run = ov_r & granted & en;
  wire ivl_busy = ivl_r != 16'h0000;
  wire ph_end = xph_r == 2'(MCC - 1);
  wire hs_hold = (oxm == xm_single) & ~dreq_low_in[own_r]; // [RULE22]
  wire fault = bus_parity_error_in | memory_protect_fault_in
    | external_address_fault_in;
  wire ferr = run & ~ivl_busy & ph_end & fault; // [RULE19]
  wire wdone = run & ~ivl_busy & ph_end & ~rdy_low_in & ~hs_hold & ~fault;
  wire last = cnt_r[own_r] <= 16'h0001;
  wire bdone = wdone & last;
  wire udone = wdone & ~last & ((oxm == xm_single) | (oxm == xm_area_ext)
    | ((oxm == xm_double) & ucnt_r)); // [RULE14]
  wire glost = ov_r & ~granted & burst; // [RULE15]
  logic [NCH-1:0] kill, frst, wcm, wcs, mine, fdone, fbad;
  wire drop = kill[own_r] | frst[own_r];

  dcs_arb u_arb (
    .el_in(el),
    .order_in(order_r),
    .win_out(win),
    .any_out(wany)
  ); // [RULE24]

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ov_r <= 1'b0;
      own_r <= 2'h0;
      xph_r <= 2'h0;
      ucnt_r <= 1'b0;
      ivl_r <= 16'h0000;
    end else if (take) begin
      ov_r <= 1'b1;
      own_r <= win;
      xph_r <= 2'h0;
      ucnt_r <= 1'b0;
    end else begin
      ov_r <= ov_r & ~(bdone | udone | ferr | glost | drop); // [RULE13]
      if (run & ~ivl_busy) xph_r <= ph_end ? 2'h0 : xph_r + 2'h1;
      if (wdone) ucnt_r <= ~ucnt_r;
      // interval is counted in machine cycles before the next word
      if (wdone & burst & mw_r[own_r][`DCS_MW_IVL] & ~last)
        ivl_r <= ivw_r[own_r]; // [RULE16]
      else if (ivl_busy & mc_tick)
        ivl_r <= ivl_r - 16'h0001;
    end
  end

  // single and double give the bus back once granted; burst keeps it
  wire want = (wany & ~ov_r) | (ov_r & burst & ~last); // [RULE21] [RULE15]
  assign bus_request_low_out = ~(en & want);

  // ==========================================================
  // per-channel instruction registers
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      for (int c = 0; c < NCH; c++) begin
        mw_r[c] <= 16'h0000;
        adr_r[c] <= 16'h0000;
        cnt_r[c] <= 16'h0000;
        ivw_r[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (fstep & fok & (fc_r == 2'(c))) begin
          case (3'(fw_r))
            `DCS_W_MODE: mw_r[c] <= fword[15:0];
            `DCS_W_ADR: adr_r[c] <= fword[15:0];
            `DCS_W_CNT: cnt_r[c] <= fword[15:0];
            `DCS_W_IVL: ivw_r[c] <= fword[15:0];
            default: ;
          endcase
        end else if (wdone & mine[c]) begin
          adr_r[c] <= adr_r[c] + 16'h0001;
          cnt_r[c] <= cnt_r[c] - 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // per-channel control and status flags
  // hardware set wins over a software clear in the same cycle
  logic [3:0] eset [NCH];
  logic [3:0] eclr [NCH];

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      act_r <= '0;
      crqp_r <= '0;
      end_of_transfer_flag_r <= '0;
      fetched_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        ins_r[c] <= '0;
        err_r[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wcm[c]) begin
          act_r[c] <= pwdata_in[`DCS_CM_ACT];
          ins_r[c] <= pwdata_in[`DCS_CM_INS_LSB +: IW];
        end else if (mine[c] & bdone & ochain) begin
          ins_r[c] <= mw_r[c][`DCS_MW_LINK_LSB +: IW]; // [RULE17]
        end
        crqp_r[c] <= (wcs[c] & pwdata_in[`DCS_CS_RQP])
          | (crqp_r[c] & ~frst[c] & ~(take & (win == 2'(c))));
        end_of_transfer_flag_r[c] <= (mine[c] & bdone & ~ochain)
          | (end_of_transfer_flag_r[c] & ~frst[c]
          & ~(wcs[c] & pwdata_in[`DCS_CS_END])); // [RULE17]
        err_r[c] <= eset[c] | (err_r[c] & ~eclr[c]); // [RULE20]
        fetched_r[c] <= (st[c] == await_instruction_state)
          & (fetched_r[c] | fdone[c]);
      end
    end
  end

  // ==========================================================
  // channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    dcs_ch_if cif ();
    wire me = ov_r & (own_r == 2'(c));
    assign mine[c] = me;
    assign wcm[c] = wr & a_cm & aligned & (ach == 2'(c));
    assign wcs[c] = wr & a_cs & aligned & (ach == 2'(c));
    assign frst[c] = wcs[c] & pwdata_in[`DCS_CS_RST]; // [RULE7]
    assign kill[c] = wcm[c] & ~pwdata_in[`DCS_CM_ACT]; // [RULE18]
    assign fdone[c] = fstep & fok & flast & (fc_r == 2'(c));
    assign fbad[c] = fstep & ~fok & (fc_r == 2'(c)); // [RULE9]
    assign fneed[c] = en & (st[c] == await_instruction_state)
      & ~fetched_r[c] & ~end_of_transfer_flag_r[c];
    assign el[c] = en & (((st[c] == await_grant_state)
      & mw_r[c][`DCS_MW_ACT]) | (st[c] == await_regrant_state));
    assign eset[c] = {me & ferr & external_address_fault_in,
      me & ferr & memory_protect_fault_in,
      me & ferr & bus_parity_error_in, fbad[c]}; // [RULE19]
    assign eclr[c] = frst[c] ? 4'hf
      : (wcs[c] ? pwdata_in[`DCS_CS_ERR_LSB +: 4] : 4'h0);
    // mode write carries no parity check on activation
    assign cif.activate = wcm[c] & pwdata_in[`DCS_CM_ACT]; // [RULE8]
    assign cif.kill = kill[c];
    assign cif.frst = frst[c];
    assign cif.fetch_ok = fetched_r[c];
    // masking gates only the external request line
    assign cif.req = en & ((~dreq_low_in[c] & ~mask_r[c]) | crqp_r[c]); // [RULE10]
    assign cif.link_act = mw_r[c][`DCS_MW_ACT]; // [RULE11]
    assign cif.win = take & (win == 2'(c)); // [RULE12]
    assign cif.udone = me & udone;
    assign cif.bdone = me & bdone;
    assign cif.chained = ochain;
    assign cif.glost = me & glost;
    assign cif.err = |err_r[c];
    assign cif.end_flag = end_of_transfer_flag_r[c];
    assign st[c] = cif.st;
    assign dack_low_out[c] = ~(me & granted); // [RULE25]
    assign ch_state_busy_out[c] = cif.st != idle_state;

    dcs_chan u_chan (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .cif(cif.chan)
    );
  end

  // ==========================================================
  // interrupt and bus address
  logic any_err;
  always_comb begin
    any_err = 1'b0;
    for (int c = 0; c < NCH; c++)
      any_err = any_err | (st[c] == error_state);
  end

  // one pulse per rise of the combined error level, not per channel
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      any_err_d_r <= 1'b0;
      irq_r <= 1'b1;
      baddr_r <= 16'h0000;
    end else begin
      any_err_d_r <= any_err;
      irq_r <= ~(any_err & ~any_err_d_r); // [RULE20] [RULE23]
      if (ov_r) baddr_r <= adr_r[own_r];
    end
  end

  assign interrupt_out_low = irq_r;
  assign bus_addr_out = baddr_r;
endmodule : dcs_top
`default_nettype wire

// [include/dcs_cfg.svh]
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
// ==========================================================
// register map, byte addresses on the apb side
`define DCS_AW 12
`define DCS_A_GMODE 12'h000
`define DCS_PG_CMODE 8'h01
`define DCS_PG_CSTAT 8'h02
`define DCS_PG_RAM 4'h1
// ==========================================================
// global mode/status fields and reset values
`define DCS_G_PAR 0
`define DCS_G_MASK_LSB 4
`define DCS_G_ORD_LSB 8
`define DCS_RST_PAR 1'b1
`define DCS_RST_MASK 4'hf
`define DCS_RST_ORD 8'he4
// ==========================================================
// channel mode and channel status fields
`define DCS_CM_ACT 0
`define DCS_CM_INS_LSB 1
`define DCS_CS_RQP 0
`define DCS_CS_END 1
`define DCS_CS_ERR_LSB 2
`define DCS_CS_RST 7
// ==========================================================
// instruction mode/link word and word slots
`define DCS_MW_ACT 0
`define DCS_MW_CHAIN 1
`define DCS_MW_XM_LSB 2
`define DCS_MW_IVL 4
`define DCS_MW_LINK_LSB 5
`define DCS_W_MODE 3'h0
`define DCS_W_ADR 3'h1
`define DCS_W_CNT 3'h2
`define DCS_W_IVL 3'h3
// ==========================================================
// timing and configuration snoop
`define DCS_CLK_NS 10
`define DCS_MC_NS 20
`define DCS_MC_CLKS (`DCS_MC_NS / `DCS_CLK_NS)
`define DCS_CFG_ADDR 16'h8410
`define DCS_CFG_PAR_BIT 0
`endif

// [include/dcs_ch_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface dcs_ch_if;
  logic activate;
  logic kill;
  logic frst;
  logic fetch_ok;
  logic req;
  logic link_act;
  logic win;
  logic udone;
  logic bdone;
  logic chained;
  logic glost;
  logic err;
  logic end_flag;
  dcs_pkg::dcs_state_e st;
  modport ctl(output activate, kill, frst, fetch_ok, req, link_act, win,
    udone, bdone, chained, glost, err, end_flag, input st);
  modport chan(input activate, kill, frst, fetch_ok, req, link_act, win,
    udone, bdone, chained, glost, err, end_flag, output st);
endinterface : dcs_ch_if
`default_nettype wire

// [include/dcs_pkg.sv]
package dcs_pkg;
  typedef enum logic [2:0] {
    idle_state = 3'b000,
    await_instruction_state = 3'b001,
    await_grant_state = 3'b010,
    transfer_state = 3'b011,
    await_regrant_state = 3'b100,
    error_state = 3'b101
  } dcs_state_e;
  typedef enum logic [1:0] {
    xm_single = 2'b00,
    xm_double = 2'b01,
    xm_area_ext = 2'b10,
    xm_area_burst = 2'b11
  } dcs_xm_e;
  typedef logic [7:0] dcs_order_t;
endpackage : dcs_pkg

// [verification/dcs_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module dcs_checker (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic controller_enable_pin_in,
  input wire logic bus_grant_low_in,
  input wire logic [3:0] dack_low_out,
  input wire logic bus_request_low_out,
  input wire logic interrupt_out_low,
  input wire logic [3:0] ch_state_busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn_in |=> &dack_low_out && bus_request_low_out && interrupt_out_low)
    else $error("outputs not quiet after reset");
  a_ack_grant: assert property (
    dack_low_out != 4'hf |-> !bus_grant_low_in)
    else $error("acknowledge without grant");
  a_ack_single: assert property ($onehot0(~dack_low_out))
    else $error("two channels acknowledged");
  a_irq_pulse: assert property (
    $fell(interrupt_out_low) |=> interrupt_out_low)
    else $error("interrupt longer than one cycle");
  a_irq_error: assert property (
    !interrupt_out_low |-> ch_state_busy_out != 4'h0)
    else $error("interrupt with all channels idle");
  a_idle_quiet: assert property (
    ch_state_busy_out == 4'h0 |-> bus_request_low_out && &dack_low_out)
    else $error("bus activity while idle");
  a_ack_busy: assert property (
    (ch_state_busy_out | dack_low_out) == 4'hf)
    else $error("idle channel acknowledged");
  a_off_no_req: assert property (
    !controller_enable_pin_in && $past(!controller_enable_pin_in)
    && &dack_low_out |-> bus_request_low_out)
    else $error("request while disabled");
endmodule : dcs_checker
bind dcs_top dcs_checker u_chk (.core_clk_in, .rstn_in,
  .controller_enable_pin_in, .bus_grant_low_in, .dack_low_out,
  .bus_request_low_out, .interrupt_out_low, .ch_state_busy_out);
`default_nettype wire

// [verification/dcs_far.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// arbiter and i/o ports facing the controller
module dcs_far (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic slow_in,
  input wire logic [3:0] want_in,
  input wire logic bus_request_low_in,
  input wire logic [3:0] dack_low_in,
  output logic bus_grant_low_out,
  output logic rdy_low_out,
  output logic [3:0] dreq_low_out
);
  logic [1:0] wait_r;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      bus_grant_low_out <= 1'b1;
      rdy_low_out <= 1'b1;
      dreq_low_out <= 4'hf;
      wait_r <= 2'h0;
    end else begin
      // grant held for the whole acknowledged cycle
      bus_grant_low_out <= bus_request_low_in & (&dack_low_in);
      // slow memory stretches the cycle by up to three clocks
      wait_r <= (&dack_low_in) ? {slow_in, slow_in} : wait_r - |wait_r;
      rdy_low_out <= &dack_low_in || wait_r != 2'h0;
      // port drops its request once data is taken
      dreq_low_out <= ~want_in | (~dack_low_in & {4{~rdy_low_out}});
    end
  end
endmodule : dcs_far
`default_nettype wire

// [verification/tb_dma_channel_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_dma_channel_sequencer;
  logic core_clk_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0;
  logic penable_in = 1'b0, pwrite_in = 1'b0, io_cfg_rd_in = 1'b0;
  logic controller_enable_pin_in = 1'b1, slow = 1'b0, err;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [15:0] io_addr_in = 16'h0, io_data_in = 16'h0, bus_addr_out;
  logic [3:0] dreq_low_in, dack_low_out, ch_state_busy_out, want = 4'h0;
  logic pready_out, pslverr_out, bus_request_low_out, bus_grant_low_in;
  logic rdy_low_in, interrupt_out_low;
  logic [2:0] flt = 3'h0;
  logic [7:0] seed = 8'h1e;
  dcs_pkg::dcs_order_t fetch_order_in = 8'he4;
  int error_cnt = 0, compares = 0, cyc = 0, irq_n = 0;
  dcs_top dut (.core_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .controller_enable_pin_in, .io_cfg_rd_in, .io_addr_in, .io_data_in,
    .dreq_low_in, .dack_low_out, .bus_request_low_out, .bus_grant_low_in,
    .rdy_low_in, .bus_parity_error_in(flt[0]),
    .memory_protect_fault_in(flt[1]), .external_address_fault_in(flt[2]),
    .interrupt_out_low, .bus_addr_out, .ch_state_busy_out, .fetch_order_in);
  dcs_far far (.core_clk_in, .rstn_in, .slow_in(slow), .want_in(want),
    .bus_request_low_in(bus_request_low_out), .dack_low_in(dack_low_out),
    .bus_grant_low_out(bus_grant_low_in), .rdy_low_out(rdy_low_in),
    .dreq_low_out(dreq_low_in));
  always #5 core_clk_in = ~core_clk_in;
  // ==========================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [31:0] gexp(input logic p, input logic [3:0] m,
    input logic [7:0] o, input logic e);
    return {15'h0, e, o, m, 3'h0, p};
  endfunction : gexp
  function automatic logic [11:0] cs(input int c);
    return 12'(12'h020 + 4 * c);
  endfunction : cs
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (!interrupt_out_low) irq_n <= irq_n + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  // polls are bounded so a stuck channel shows as a mismatch
  task automatic poll(input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    for (int n = 0; n < 300 && (rd & m) !== v; n++) apb(1'b0, a, 32'h0);
    chk(rd & m, v);
  endtask : poll
  task automatic start(input int c, input logic [31:0] mw,
    input logic [31:0] n);
    apb(1'b1, 12'(12'h100 + 32 * c), mw);
    apb(1'b1, 12'(12'h108 + 32 * c), n);
    apb(1'b1, 12'(12'h010 + 4 * c), 32'(2 * c + 1));
  endtask : start
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, gexp(1'b1, 4'hf, 8'he4, 1'b1));
    controller_enable_pin_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[16], 32'h0);
    controller_enable_pin_in <= 1'b1;
    io_cfg_rd_in <= 1'b1;
    io_addr_in <= 16'h8410;
    @(posedge core_clk_in);
    io_cfg_rd_in <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[0], 32'h0);
    apb(1'b1, 12'h000, gexp(1'b1, 4'h0, 8'h1b, 1'b0));
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, gexp(1'b1, 4'h0, 8'h1b, 1'b1));
    apb(1'b0, 12'h0f0, 32'h0);
    chk(err, 32'h1);
    // every instruction word is read back with parity, so none may stay unknown
    for (int i = 0; i < 64; i++) apb(1'b1, 12'(12'h100 + 4 * i), 32'h0);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      slow <= seed[0];
      start(k, 32'(1 + 4 * k), 32'(2 + 2 * seed[1]));
      want[k] <= 1'b1;
      poll(cs(k), 32'h2, 32'h2);
      chk(bus_addr_out, 32'(1 + 2 * seed[1]));
      want[k] <= 1'b0;
      apb(1'b1, cs(k), 32'h80);
      poll(cs(k), 32'h702, 32'h0);
    end
    start(1, 32'h0, 32'h1);
    apb(1'b1, cs(1), 32'h1);
    poll(cs(1), 32'h700, 32'h0);
    for (int k = 0; k < 3; k++) begin
      irq_n = 0;
      flt <= 3'(1 << k);
      start(0, 32'h1, 32'h4);
      want[0] <= 1'b1;
      poll(cs(0), 32'h73c, 32'h500 | (32'h8 << k));
      repeat (2) @(posedge core_clk_in);
      chk(irq_n, 32'h1);
      flt <= 3'h0;
      want[0] <= 1'b0;
      apb(1'b1, cs(0), 32'h3c);
      poll(cs(0), 32'h73c, 32'h0);
    end
    complete_run();
  end
endmodule : tb_dma_channel_sequencer
`default_nettype wire
